// >>> design/mpd_pkg.sv
// Purpose: Shared constants and types for the MII PHY-side datapath.
// Assumes: Management frames are decoded elsewhere into mpd_req_s requests.
// Notes: Offsets are 5-bit management register addresses.
package mpd_pkg;
   localparam logic [4:0] ADR_BASIC = 5'h00;
   localparam logic [4:0] ADR_STATUS = 5'h10;
   localparam logic [4:0] ADR_LED = 5'h18;
   localparam logic [4:0] ADR_PHYCTL = 5'h19;
   localparam logic [4:0] ADR_DIAG = 5'h1B;
   localparam int BC_LOOP = 14;
   localparam int BC_SPD = 13;
   localparam int BC_AN = 12;
   localparam int BC_DUP = 8;
   localparam logic [15:0] BASIC_RST = 16'h3000;
   localparam int ST_LOOP = 3;
   localparam int ST_DUP = 2;
   localparam int ST_SPD10 = 1;
   localparam int PC_PSR15 = 11;
   localparam int PC_START = 10;
   localparam int PC_PASS = 9;
   localparam int DG_ERR_LO = 8;
   localparam int DG_CONT = 5;
   localparam int DG_HB = 4;
   localparam int LED_EN_LO = 3;
   localparam int NIB_BITS = 4;
   localparam int COL_HOLD_BITS = 7;
   localparam int LINK10_PERIOD_NS = 400;
   localparam int HB_DELAY_NS = 1000;
   localparam int HB_PULSE_BITS = 10;
   localparam int HB_DLY_CYC = (HB_DELAY_NS / LINK10_PERIOD_NS < 1) ? 1 : HB_DELAY_NS / LINK10_PERIOD_NS;
   localparam int HB_PULSE_CYC = (HB_PULSE_BITS + NIB_BITS - 1) / NIB_BITS;
   localparam int PRIME_NIBS = 4;
   localparam int PASS_NIBS = 16;
   localparam int BUILT_IN_SELF_TEST_PKT_NIBS = 48;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mpd_req_s;
   typedef struct packed {
      logic en;
      logic [3:0] d;
   } mpd_tx_s;
   typedef struct packed {
      logic dv;
      logic er;
      logic [3:0] d;
   } mpd_rx_s;
   typedef struct packed {
      logic squelch_ok;
      logic signal_detect;
      logic two_zeros;
      logic eop;
   } mpd_det_s;
   typedef struct packed {
      logic loop;
      logic spd100;
      logic full;
      logic hb;
      logic psr15;
      logic cont;
      logic run;
   } mpd_cfg_s;
endpackage

// >>> design/mpd_datapath.sv
// Purpose: PHY-side MII datapath with carrier, collision, loopback and self-test.
// Assumes: line_clk is the nibble clock at the resolved rate; media signals share it.
// Notes: Registers live on clk; link logic on line_clk; crossings are synchronised.
module mpd_datapath (
   input wire logic clk,
   input wire logic arst_n,
   input wire mpd_pkg::mpd_req_s req,
   output logic [15:0] reg_rdata,
   input wire logic an_done,
   input wire logic an_parallel,
   input wire logic an_spd100,
   input wire logic an_full,
   input wire logic [2:0] led_func,
   output logic [2:0] led_o,
   output logic line_rate_100,
   input wire logic line_clk,
   output logic mii_tx_clk,
   output logic mii_rx_clk,
   input wire mpd_pkg::mpd_tx_s mii_tx,
   output mpd_pkg::mpd_rx_s mii_rx,
   output logic mii_crs,
   output logic mii_col,
   input wire mpd_pkg::mpd_rx_s med_rx,
   input wire mpd_pkg::mpd_det_s med_det,
   output mpd_pkg::mpd_tx_s med_tx
);
   import mpd_pkg::*;

   function automatic logic [19:0] pr_step(input logic [14:0] s, input logic l15,
                                            input logic [3:0] din, input logic chk);
      logic [14:0] t;
      logic [3:0] n;
      logic b;
      logic e;
      t = s;
      n = 4'h0;
      e = 1'b0;
      for (int i = 0; i < NIB_BITS; i++) begin
         b = l15 ? (t[14] ^ t[13]) : (t[8] ^ t[4]);
         n[i] = b;
         e = e | (chk & (b != din[i]));
         t = {t[13:0], chk ? din[i] : b};
      end
      return {e, t, n};
   endfunction

   function automatic logic [7:0] g2b(input logic [7:0] g);
      logic [7:0] b;
      b = {g[7], 7'h00};
      for (int i = 6; i >= 0; i--) begin
         b[i] = g[i] ^ b[i + 1];
      end
      return b;
   endfunction

   // ---------------------------------------------------------------
   // Registers on the management side.
   // ---------------------------------------------------------------
   logic [15:0] basic_r;
   logic [15:0] led_r;
   logic psr15_r;
   logic start_r;
   logic cont_r;
   logic hb_r;
   logic start_tog_r;
   logic res_spd_r;
   logic res_full_r;
   logic [15:0] rdata_r;
   logic [2:0] led_out_r;
   logic pass_m_r;
   logic pass_q_r;
   logic [7:0] gray_m_r;
   logic [7:0] gray_q_r;
   logic pass_r;
   logic [7:0] gray_r;
   logic spd100;
   logic dup_full;
   mpd_cfg_s cfg;

   assign spd100 = basic_r[BC_AN] ? res_spd_r : basic_r[BC_SPD];
   assign dup_full = basic_r[BC_AN] ? res_full_r : basic_r[BC_DUP];
   assign cfg = '{loop: basic_r[BC_LOOP], spd100: spd100, full: dup_full, hb: hb_r,
                  psr15: psr15_r, cont: cont_r, run: start_r};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         basic_r <= BASIC_RST;
         led_r <= 16'h0000;
         psr15_r <= 1'b0;
         start_r <= 1'b0;
         cont_r <= 1'b0;
         hb_r <= 1'b0;
         start_tog_r <= 1'b0;
      end else if (req.wr) begin
         unique case (req.addr)
            ADR_BASIC: basic_r <= req.wdata;
            ADR_LED: led_r <= req.wdata;
            ADR_PHYCTL: begin
               psr15_r <= req.wdata[PC_PSR15];
               start_r <= req.wdata[PC_START];
               start_tog_r <= ~start_tog_r;
            end
            ADR_DIAG: begin
               cont_r <= req.wdata[DG_CONT];
               hb_r <= req.wdata[DG_HB];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         res_spd_r <= 1'b1;
         res_full_r <= 1'b0;
      end else if (an_done) begin
         res_spd_r <= an_spd100;
         res_full_r <= an_parallel ? 1'b0 : an_full;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pass_m_r <= 1'b0;
         pass_q_r <= 1'b0;
         gray_m_r <= 8'h00;
         gray_q_r <= 8'h00;
      end else begin
         pass_m_r <= pass_r;
         pass_q_r <= pass_m_r;
         gray_m_r <= gray_r;
         gray_q_r <= gray_m_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 16'h0000;
      end else if (req.rd) begin
         unique case (req.addr)
            ADR_BASIC: rdata_r <= basic_r;
            ADR_STATUS: rdata_r <= {13'h0000, dup_full, ~spd100, 1'b0} |
                                   (16'h0001 << ST_LOOP) & {16{basic_r[BC_LOOP]}};
            ADR_LED: rdata_r <= led_r;
            ADR_PHYCTL: rdata_r <= {4'h0, psr15_r, start_r, pass_q_r, 9'h000};
            ADR_DIAG: rdata_r <= {g2b(gray_q_r), 2'h0, cont_r, hb_r, 4'h0};
            default: rdata_r <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         led_out_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            led_out_r[i] <= led_r[LED_EN_LO + i] ? led_r[i] : led_func[i];
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign led_o = led_out_r;
   assign line_rate_100 = spd100;
   assign mii_tx_clk = line_clk;
   assign mii_rx_clk = line_clk;

   // ---------------------------------------------------------------
   // Crossing into the link domain.
   // ---------------------------------------------------------------
   logic lrst_m_r;
   logic lrst_n;
   mpd_cfg_s cfg_m_r;
   mpd_cfg_s lc;
   logic tog_m_r;
   logic tog_q_r;
   logic tog_d_r;
   logic start_evt;

   always_ff @(posedge line_clk or negedge arst_n) begin
      if (!arst_n) begin
         lrst_m_r <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_m_r <= 1'b1;
         lrst_n <= lrst_m_r;
      end
   end

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         cfg_m_r <= '0;
         lc <= '0;
         tog_m_r <= 1'b0;
         tog_q_r <= 1'b0;
         tog_d_r <= 1'b0;
      end else begin
         cfg_m_r <= cfg;
         lc <= cfg_m_r;
         tog_m_r <= start_tog_r;
         tog_q_r <= tog_m_r;
         tog_d_r <= tog_q_r;
      end
   end
   assign start_evt = tog_q_r ^ tog_d_r;

   // ---------------------------------------------------------------
   // Carrier sense and collision.
   // ---------------------------------------------------------------
   logic rx_car_r;
   logic rx_car;
   logic tx_act;
   logic coll;
   logic rx_first_r;
   logic rx_first;
   logic [3:0] bits_r;
   logic col_now;
   logic tx_prev_r;
   logic [2:0] hb_cnt_r;
   logic hb_on;
   logic crs_r;
   logic col_r;
   logic built_in_self_test_en;

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_car_r <= 1'b0;
      end else if (med_det.eop) begin
         rx_car_r <= 1'b0;
      end else if (lc.spd100 ? (med_det.signal_detect && med_det.two_zeros) : med_det.squelch_ok) begin
         rx_car_r <= 1'b1;
      end
   end

   assign tx_act = mii_tx.en | built_in_self_test_en;
   assign rx_car = lc.loop ? mii_tx.en : rx_car_r;
   assign coll = tx_act && rx_car_r && !lc.full && !lc.loop;
   assign rx_first = rx_car_r && (rx_first_r || !tx_act);
   assign col_now = coll && (rx_first || lc.spd100 || bits_r >= 4'(COL_HOLD_BITS));
   assign hb_on = hb_cnt_r > 3'(HB_DLY_CYC);

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_first_r <= 1'b0;
         bits_r <= 4'h0;
      end else begin
         rx_first_r <= rx_first;
         if (!coll) begin
            bits_r <= 4'h0;
         end else if (bits_r < 4'(COL_HOLD_BITS)) begin
            bits_r <= bits_r + 4'(NIB_BITS);
         end
      end
   end

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_prev_r <= 1'b0;
         hb_cnt_r <= 3'h0;
      end else begin
         tx_prev_r <= mii_tx.en;
         if (tx_prev_r && !mii_tx.en && lc.hb && !lc.spd100 && !lc.full && !lc.loop) begin
            hb_cnt_r <= 3'h1;
         end else if (hb_cnt_r == 3'(HB_DLY_CYC + HB_PULSE_CYC)) begin
            hb_cnt_r <= 3'h0;
         end else if (hb_cnt_r != 3'h0) begin
            hb_cnt_r <= hb_cnt_r + 3'h1;
         end
      end
   end

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         crs_r <= 1'b0;
         col_r <= 1'b0;
      end else begin
         crs_r <= rx_car | (!lc.full & tx_act);
         col_r <= !lc.full && (col_now || hb_on);
      end
   end
   assign mii_crs = crs_r;
   assign mii_col = col_r;

   // ---------------------------------------------------------------
   // Transmit path, loopback and MII receive outputs.
   // ---------------------------------------------------------------
   logic [14:0] gen_r;
   logic [19:0] gen_nxt;
   logic [5:0] brst_r;
   mpd_tx_s tx_r;
   mpd_tx_s med_tx_r;
   mpd_rx_s rx_r;

   assign gen_nxt = pr_step(gen_r, lc.psr15, 4'h0, 1'b0);
   assign built_in_self_test_en = lc.run && (lc.cont || brst_r < 6'(BUILT_IN_SELF_TEST_PKT_NIBS));

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         gen_r <= 15'h7FFF;
         brst_r <= 6'h00;
      end else if (lc.run) begin
         // The generator pauses in burst gaps so that the self-syncing checker stays aligned.
         if (built_in_self_test_en) begin
            gen_r <= gen_nxt[18:4];
         end
         brst_r <= brst_r + 6'h01;
      end else begin
         brst_r <= 6'h00;
      end
   end

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_r <= '0;
         med_tx_r <= '0;
         rx_r <= '0;
      end else begin
         tx_r <= lc.run ? mpd_tx_s'{en: built_in_self_test_en, d: gen_nxt[3:0]} : mii_tx;
         med_tx_r <= lc.loop ? '0 : (lc.run ? mpd_tx_s'{en: built_in_self_test_en, d: gen_nxt[3:0]} : mii_tx);
         rx_r <= lc.loop ? mpd_rx_s'{dv: mii_tx.en, er: 1'b0, d: mii_tx.d} : med_rx;
      end
   end
   assign med_tx = med_tx_r;
   assign mii_rx = rx_r;

   // ---------------------------------------------------------------
   // Self-test checker.
   // ---------------------------------------------------------------
   mpd_rx_s chk_in;
   logic [14:0] hist_r;
   logic [19:0] chk_nxt;
   logic [2:0] prime_r;
   logic [4:0] good_r;
   logic fail_r;
   logic [7:0] err_cnt_r;
   logic err_hit;
   logic [7:0] cnt_nxt;

   assign chk_in = lc.loop ? mpd_rx_s'{dv: tx_r.en, er: 1'b0, d: tx_r.d} : med_rx;
   assign chk_nxt = pr_step(hist_r, lc.psr15, chk_in.d, 1'b1);
   assign err_hit = lc.run && chk_in.dv && prime_r == 3'(PRIME_NIBS) && chk_nxt[19];
   assign cnt_nxt = (err_hit && err_cnt_r != 8'hFF) ? err_cnt_r + 8'h01 : err_cnt_r;

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         hist_r <= 15'h0000;
         prime_r <= 3'h0;
         good_r <= 5'h00;
         fail_r <= 1'b0;
         pass_r <= 1'b0;
      end else if (start_evt) begin
         prime_r <= 3'h0;
         good_r <= 5'h00;
         fail_r <= err_hit;
         pass_r <= 1'b0;
      end else if (lc.run && chk_in.dv) begin
         hist_r <= chk_nxt[18:4];
         if (prime_r != 3'(PRIME_NIBS)) begin
            prime_r <= prime_r + 3'h1;
         end else if (err_hit) begin
            fail_r <= 1'b1;
            pass_r <= 1'b0;
         end else if (good_r != 5'(PASS_NIBS)) begin
            good_r <= good_r + 5'h01;
         end else begin
            pass_r <= !fail_r;
         end
      end
   end

   always_ff @(posedge line_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         err_cnt_r <= 8'h00;
         gray_r <= 8'h00;
      end else if (start_evt) begin
         err_cnt_r <= 8'h00;
         gray_r <= 8'h00;
      end else begin
         err_cnt_r <= cnt_nxt;
         gray_r <= cnt_nxt ^ (cnt_nxt >> 1);
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   sequence s_tx_coll_on;
      !lc.spd100 && $rose(coll) && $past(tx_act) && !rx_first && !hb_on;
   endsequence
   sequence s_tx_end_hb;
      $fell(mii_tx.en) && lc.hb && !lc.spd100 && !lc.full && !lc.loop && !coll && hb_cnt_r == 3'h0;
   endsequence

   a_fd_no_col: assert property (@(posedge line_clk) disable iff (!lrst_n)
      lc.full |=> !mii_col) else $error("collision reported in full duplex");
   a_hd_crs_tx: assert property (@(posedge line_clk) disable iff (!lrst_n)
      !lc.full && mii_tx.en |=> mii_crs) else $error("no carrier during half-duplex transmit");
   a_fd_crs_rx: assert property (@(posedge line_clk) disable iff (!lrst_n)
      lc.full && !rx_car |=> !mii_crs) else $error("carrier without receive in full duplex");
   a_loop_quiet: assert property (@(posedge line_clk) disable iff (!lrst_n)
      lc.loop |=> !med_tx.en) else $error("media driven during loopback");
   a_loop_route: assert property (@(posedge line_clk) disable iff (!lrst_n)
      lc.loop && mii_tx.en |=> mii_rx.dv && mii_rx.d == $past(mii_tx.d)) else $error("loopback data lost");
   a_col10_hold: assert property (@(posedge line_clk) disable iff (!lrst_n)
      s_tx_coll_on |=> !mii_col ##1 !mii_col) else $error("early 10M collision report");
   a_col10_rep: assert property (@(posedge line_clk) disable iff (!lrst_n)
      s_tx_coll_on ##1 coll ##1 coll |=> mii_col) else $error("10M collision not reported");
   a_rx_col_now: assert property (@(posedge line_clk) disable iff (!lrst_n)
      coll && rx_first |=> mii_col) else $error("receive collision delayed");
   a_hb_pulse: assert property (@(posedge line_clk) disable iff (!lrst_n)
      s_tx_end_hb ##1 (!coll)[*3] |-> ##1 mii_col[*3] ##1 !mii_col) else $error("heartbeat pulse wrong");
   a_built_in_self_test_latch: assert property (@(posedge line_clk) disable iff (!lrst_n)
      err_hit |=> !pass_r && fail_r) else $error("mis-compare not latched");
   a_err_count: assert property (@(posedge line_clk) disable iff (!lrst_n)
      err_hit && !start_evt && err_cnt_r < 8'hFF |=> err_cnt_r == $past(err_cnt_r) + 8'h01)
      else $error("error count missed");
   a_pd_half: assert property (@(posedge clk) disable iff (!arst_n)
      an_done && an_parallel && basic_r[BC_AN] && !req.wr |=> !dup_full) else $error("parallel detect not half");
   a_led_force: assert property (@(posedge clk) disable iff (!arst_n)
      led_r[LED_EN_LO] && !req.wr |=> led_o[0] == $past(led_r[0])) else $error("LED override ignored");
endmodule

// >>> bench/mpd_mac_model.sv
// Purpose: Behavioural MAC on the transmit side of the MII.
// Assumes: The MAC launches each nibble just after a rising transmit clock.
// Notes: Idle data lines show the inverse of the last nibble.
module mpd_mac_model (
   input wire logic tx_clk,
   output mpd_pkg::mpd_tx_s tx
);
   timeunit 1ns;
   timeprecision 100ps;
   import mpd_pkg::*;
   initial tx = '0;
   // ------------------------------------------------------------
   // Transmit driver
   // ------------------------------------------------------------
   task automatic drive(input logic en, input logic [3:0] d);
      @(posedge tx_clk);
      tx <= '{en: en, d: (en ? d : ~tx.d)};
   endtask
endmodule

// >>> bench/tb_mpd_datapath.sv
// Purpose: Self-checking bench for the MII PHY-side datapath.
// Assumes: The link clock runs at 80 ns in every mode.
// Notes: Scenarios run in order and share the register tasks.
module tb_mpd_datapath;
   timeunit 1ns;
   timeprecision 100ps;
   import mpd_pkg::*;
   logic clk, arst_n, line_clk, an_done, an_parallel, an_spd100, an_full;
   logic line_rate_100, mii_tx_clk, mii_rx_clk, mii_crs, mii_col;
   logic [2:0] led_func, led_o;
   logic [15:0] reg_rdata, v;
   mpd_req_s req;
   mpd_tx_s mii_tx, med_tx;
   mpd_rx_s mii_rx, med_rx;
   mpd_det_s med_det;
   int error_cnt, tests_run, n;
   mpd_datapath dut (.clk(clk), .arst_n(arst_n), .req(req), .reg_rdata(reg_rdata),
      .an_done(an_done), .an_parallel(an_parallel), .an_spd100(an_spd100), .an_full(an_full),
      .led_func(led_func), .led_o(led_o), .line_rate_100(line_rate_100), .line_clk(line_clk),
      .mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk), .mii_tx(mii_tx), .mii_rx(mii_rx),
      .mii_crs(mii_crs), .mii_col(mii_col), .med_rx(med_rx), .med_det(med_det), .med_tx(med_tx));
   mpd_mac_model mac (.tx_clk(mii_tx_clk), .tx(mii_tx));
   // ------------------------------------------------------------
   // Clocks and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      line_clk = 1'b0;
      #7;
      forever #40 line_clk = ~line_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic lw(input int k);
      repeat (k) @(posedge line_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
   task automatic med(input logic [3:0] f);
      @(posedge line_clk);
      med_det <= {f[3:1], 1'b0};
      med_rx <= {f[0], 1'b0, 4'h5};
   endtask
   task automatic eop();
      @(posedge line_clk);
      med_det <= 4'h1;
      med_rx <= 6'h00;
      @(posedge line_clk);
      med_det <= 4'h0;
   endtask
   task automatic end_of_test();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd(ADR_BASIC, v);
      chk(v, BASIC_RST);
      rd(ADR_PHYCTL, v);
      chk(v[PC_PASS], 1'b0);
      chk(line_rate_100, 1'b1);
      chk(mii_rx_clk, line_clk);
      wr(5'h05, 16'hFFFF);
      rd(5'h05, v);
      chk(v, 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_pd();
      @(posedge clk);
      an_parallel <= 1'b1;
      an_full <= 1'b1;
      an_done <= 1'b1;
      @(posedge clk);
      an_done <= 1'b0;
      rd(ADR_STATUS, v);
      chk(v & 16'h0006, 16'h0002);
      lw(4);
      chk(line_rate_100, 1'b0);
      $display("parallel detect test done");
   endtask
   task automatic t_led();
      @(posedge clk);
      led_func <= 3'h3;
      wr(ADR_LED, 16'h001C);
      rd(ADR_LED, v);
      chk(led_o, 3'h0);
      chk(v, 16'h001C);
      @(posedge clk);
      led_func <= 3'h4;
      rd(ADR_LED, v);
      chk(led_o, 3'h4);
      chk(v, 16'h001C);
      $display("led test done");
   endtask
   task automatic t_half();
      wr(ADR_BASIC, 16'h2000);
      lw(4);
      med(4'h4);
      lw(3);
      chk(mii_crs, 1'b0);
      med(4'h7);
      lw(2);
      chk(mii_crs, 1'b1);
      chk(mii_col, 1'b0);
      mac.drive(1'b1, 4'h3);
      lw(2);
      chk(mii_col, 1'b1);
      mac.drive(1'b0, 4'h0);
      lw(3);
      chk(mii_col, 1'b0);
      eop();
      lw(3);
      chk(mii_crs, 1'b0);
      mac.drive(1'b1, 4'hA);
      lw(2);
      chk(mii_crs, 1'b1);
      mac.drive(1'b0, 4'h0);
      lw(3);
      chk(mii_crs, 1'b0);
      $display("half duplex test done");
   endtask
   task automatic t_full();
      wr(ADR_BASIC, 16'h2100);
      lw(4);
      mac.drive(1'b1, 4'h6);
      lw(2);
      chk(mii_crs, 1'b0);
      med(4'h7);
      lw(2);
      chk(mii_crs, 1'b1);
      lw(2);
      chk(mii_col, 1'b0);
      mac.drive(1'b0, 4'h0);
      eop();
      lw(3);
      $display("full duplex test done");
   endtask
   task automatic t_ten();
      wr(ADR_BASIC, 16'h0000);
      wr(ADR_DIAG, 16'h0010);
      lw(4);
      chk(line_rate_100, 1'b0);
      mac.drive(1'b1, 4'h9);
      lw(3);
      med(4'h9);
      lw(2);
      chk(mii_col, 1'b0);
      lw(1);
      chk(mii_col, 1'b0);
      lw(1);
      chk(mii_col, 1'b1);
      lw(2);
      chk(mii_col, 1'b1);
      eop();
      lw(3);
      mac.drive(1'b0, 4'h0);
      lw(3);
      chk(mii_col, 1'b0);
      lw(1);
      chk(mii_col, 1'b1);
      lw(2);
      chk(mii_col, 1'b1);
      lw(1);
      chk(mii_col, 1'b0);
      wr(ADR_DIAG, 16'h0000);
      $display("ten megabit test done");
   endtask
   task automatic t_loop();
      wr(ADR_BASIC, 16'h6100);
      rd(ADR_STATUS, v);
      chk(v[ST_LOOP], 1'b1);
      lw(4);
      for (int i = 0; i < 10; i++) begin
         mac.drive(1'b1, 4'(i));
         #1;
         if (i > 0) chk({mii_rx.dv, mii_rx.d}, {1'b1, 4'(i - 1)});
         chk(med_tx.en, 1'b0);
      end
      mac.drive(1'b0, 4'h0);
      $display("loopback test done");
   endtask
   task automatic t_built_in_self_test();
      for (int p = 0; p < 2; p++) begin
         wr(ADR_PHYCTL, p[0] ? 16'h0C00 : 16'h0400);
         lw(6);
         n = 0;
         v = 16'h0000;
         while (v[PC_PASS] !== 1'b1 && n < 300) begin
            rd(ADR_PHYCTL, v);
            n++;
         end
         chk(v[PC_PASS], 1'b1);
         rd(ADR_DIAG, v);
         chk(v[15:8], 8'h00);
         wr(ADR_PHYCTL, 16'h0000);
      end
      $display("self-test pass done");
   endtask
   task automatic t_cont();
      wr(ADR_BASIC, 16'h6100);
      wr(ADR_DIAG, 16'h0020);
      wr(ADR_PHYCTL, 16'h0400);
      lw(40);
      rd(ADR_PHYCTL, v);
      chk(v[PC_PASS], 1'b1);
      wr(ADR_BASIC, 16'h2100);
      med(4'h5);
      lw(8);
      chk(16'(mii_rx), 16'h0025);
      n = 0;
      repeat (80) begin
         lw(1);
         if (med_tx.en === 1'b1) n++;
      end
      chk(16'(n), 16'h0050);
      wr(ADR_BASIC, 16'h6100);
      lw(20);
      rd(ADR_PHYCTL, v);
      chk(v[PC_PASS], 1'b0);
      rd(ADR_DIAG, v);
      chk(v[15:8] != 8'h00, 1'b1);
      wr(ADR_PHYCTL, 16'h0000);
      lw(6);
      wr(ADR_PHYCTL, 16'h0000);
      rd(ADR_DIAG, v);
      chk(v[15:8], 8'h00);
      wr(ADR_DIAG, 16'h0000);
      eop();
      $display("self-test fail done");
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      req = '0;
      an_done = 1'b0;
      an_parallel = 1'b0;
      an_spd100 = 1'b0;
      an_full = 1'b0;
      led_func = 3'h0;
      med_rx = '0;
      med_det = '0;
      error_cnt = 0;
      tests_run = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      lw(4);
      t_reset();
      t_pd();
      t_led();
      t_half();
      t_full();
      t_ten();
      t_loop();
      t_built_in_self_test();
      t_cont();
      end_of_test();
   end
   initial begin
      #2000000;
      error_cnt++;
      $display("BAD t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule
